// file: dv/osd_host_model.sv
// Host controller model: drives clear, latch strobe and parallel data.
// Assumes the bench calls its tasks; every change lands at a falling edge.
`default_nettype none

module osd_host_model
    import osd_pkg::*;
(
    input wire logic i_clk,          // Core clock
    output var logic o_clear_n,      // Clear, active low
    output var logic o_latch_strobe, // Capture strobe
    output var osd_vec_t o_data      // Parallel data, 1 = on
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle levels at time zero
    initial
    begin
        o_clear_n = 1'b1;
        o_latch_strobe = 1'b0;
        o_data = 8'h00;
    end

    // Strobe high for hold cycles; data is inverted once sampled, so a
    // device that looks again at any later rising edge is caught
    task automatic latch(input osd_vec_t v, input int hold);
        @(negedge i_clk);
        o_data = v;
        o_latch_strobe = 1'b1;
        @(negedge i_clk);
        o_data = ~v;
        repeat (hold - 1) @(negedge i_clk);
        o_latch_strobe = 1'b0;
    endtask

    // Low time below the filter length is noise to the device
    task automatic clear(input int n);
        @(negedge i_clk);
        o_clear_n = 1'b0;
        repeat (n) @(negedge i_clk);
        o_clear_n = 1'b1;
    endtask
endmodule // osd_host_model

`default_nettype wire

// file: dv/osd_sink_driver_tb_top.sv
// Self-checking bench of the sink driver control logic.
// Assumes short recovery and filter counts; the host model drives clear,
// strobe and data, the bench drives the status levels.
`default_nettype none

module osd_sink_driver_tb_top
    import osd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int RCV = 20;
    localparam int FLT = 4;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic thermal = 1'b0;
    logic supply = 1'b0;
    osd_vec_t guard = 8'h00;
    logic clear_n;
    logic strobe;
    osd_vec_t data;
    osd_vec_t outs;
    osd_vec_t trip;
    int errors = 0;
    int checks = 0;

    always #2 i_clk = ~i_clk;

    osd_host_model host_u (.i_clk(i_clk), .o_clear_n(clear_n),
        .o_latch_strobe(strobe), .o_data(data));

    osd_sink_driver #(.RECOV_CYC(RCV), .CLR_FILT_CYC(FLT)) dut_u (
        .i_clk(i_clk), .i_rst(i_rst), .i_clear_n(clear_n),
        .i_latch_strobe(strobe), .i_parallel_data_in(data),
        .i_overcurrent_guard(guard), .i_thermal_cutoff(thermal),
        .i_supply_low(supply), .o_sink_outputs(outs),
        .o_guard_tripped(trip));

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One-cycle overcurrent pulse on the masked channels
    task automatic pulse(input osd_vec_t m);
        @(negedge i_clk);
        guard = m;
        @(negedge i_clk);
        guard = 8'h00;
    endtask

    // Bounded wait for all shut-off flags to drop
    task automatic wait_free(output int n);
        n = 0;
        while (trip !== 8'h00 && n < 100)
        begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 100)
        begin
            errors++;
            conclude();
        end
    endtask

    task automatic t_capture();
        host_u.latch(8'hA5, 1);
        cyc(3);
        chk(outs, 8'hA5);
        host_u.latch(8'h5A, 4);
        cyc(3);
        chk(outs, 8'h5A);
        host_u.latch(8'hFF, 1);
        host_u.latch(8'h00, 1);
        cyc(3);
        chk(outs, 8'h00);
        $display("done: capture");
    endtask

    task automatic t_overcur();
        int n;
        host_u.latch(8'hFF, 1);
        cyc(3);
        pulse(8'h08);
        cyc(2);
        chk(outs, 8'hF7);
        chk(trip, 8'h08);
        wait_free(n);
        chk({7'h00, (n + 3 >= RCV) && (n + 3 <= RCV + 4)}, 8'h01);
        cyc(1);
        chk(outs, 8'hFF);
        pulse(8'h08);
        cyc(9);
        pulse(8'h20);
        cyc(14);
        chk(trip, 8'h28);
        chk(outs, 8'hD7);
        wait_free(n);
        chk({7'h00, (n + 15 >= RCV) && (n + 15 <= RCV + 4)}, 8'h01);
        cyc(1);
        chk(outs, 8'hFF);
        $display("done: overcurrent");
    endtask

    task automatic t_thermal();
        host_u.latch(8'h3C, 1);
        cyc(3);
        thermal = 1'b1;
        cyc(2);
        chk(outs, 8'h00);
        host_u.latch(8'hC3, 1);
        cyc(3);
        thermal = 1'b0;
        cyc(3);
        chk(outs, 8'h3C);
        thermal = 1'b1;
        host_u.clear(FLT + 2);
        thermal = 1'b0;
        cyc(3);
        chk(outs, 8'h00);
        $display("done: thermal");
    endtask

    task automatic t_clear();
        host_u.latch(8'hFF, 1);
        cyc(3);
        host_u.clear(FLT - 2);
        cyc(3);
        chk(outs, 8'hFF);
        pulse(8'h02);
        cyc(2);
        chk(trip, 8'h02);
        host_u.clear(FLT + 2);
        chk(outs, 8'h00);
        chk(trip, 8'h00);
        cyc(3);
        chk(outs, 8'h00);
        $display("done: clear");
    endtask

    task automatic t_supply();
        host_u.latch(8'h81, 1);
        cyc(3);
        supply = 1'b1;
        cyc(2);
        chk(outs, 8'h00);
        supply = 1'b0;
        cyc(3);
        chk(outs, 8'h00);
        host_u.latch(8'h81, 1);
        cyc(3);
        chk(outs, 8'h81);
        $display("done: supply");
    endtask

    // Main sequence
    initial
    begin
        cyc(12);
        i_rst = 1'b0;
        cyc(1);
        chk(outs, 8'h00);
        chk(trip, 8'h00);
        t_capture();
        t_overcur();
        t_thermal();
        t_clear();
        t_supply();
        conclude();
    end
endmodule // osd_sink_driver_tb_top

`default_nettype wire

// file: hw/osd_chan_if.sv
// Carrier between the shared control and one channel slice.
// Assumes a single clock domain; no clocking block.
`default_nettype none

interface osd_chan_if;
    logic capture; // Take the data bit this cycle
    logic data;    // Data bit to take
    logic wipe;    // Clear or power-on reset
    logic block;   // Thermal shutdown
    logic trip;    // Overcurrent seen on this channel
    logic recover; // Shared recovery interval ended
    logic on;      // Channel wants its switch on
    logic tripped; // Channel is in overcurrent shut-off

    modport ctrl (output capture, data, wipe, block, trip, recover,
                  input on, tripped);
    modport chan (input capture, data, wipe, block, trip, recover,
                  output on, tripped);
endinterface

`default_nettype wire

// file: hw/osd_channel.sv
// One channel slice: data latch and overcurrent shut-off flag.
// Assumes the control hands it one-cycle capture and recover pulses.
`default_nettype none

module osd_channel
    import osd_pkg::*;
(
    input wire logic i_clk,      // Core clock
    input wire logic i_rst,      // Synchronous reset, active high
    osd_chan_if.chan ch          // Control side
);
    osd_chan_t st_q;
    osd_chan_t st_d;

    // Next state: wipe first, then a new trip wins over recovery
    always_comb
    begin
        st_d = st_q;
        if (ch.wipe)
        begin
            st_d = '0;
        end
        else
        begin
            if (ch.capture)
            begin
                st_d.latched = ch.data;
            end
            if (ch.trip)
            begin
                st_d.tripped = 1'b1;
            end
            else if (ch.recover)
            begin
                st_d.tripped = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Trip gates the switch at once, before the flag settles
    assign ch.on = st_q.latched & ~st_q.tripped & ~ch.trip & ~ch.block
                 & ~ch.wipe;
    assign ch.tripped = st_q.tripped;

endmodule // osd_channel

`default_nettype wire

// file: hw/osd_map.svh
// Constants of the octal sink driver control logic: counts and reset values.
// Assumes a 250 MHz core clock; included by the package user files.
`ifndef OSD_MAP_SVH
`define OSD_MAP_SVH

// Channel count
`define OSD_CHANNELS 8
// Core clock rate
`define OSD_CLK_MHZ 250
// Overcurrent recovery interval, typical figure
`define OSD_RECOV_NS 10000
// Recovery interval in clock cycles
`define OSD_RECOV_CYC ((`OSD_RECOV_NS * `OSD_CLK_MHZ) / 1000)
// Clear noise filter: recognition is guaranteed within this low time
`define OSD_CLR_FILT_NS 5000
// Filter length in cycles, rounded down so a 5 us pulse always counts
`define OSD_CLR_FILT_CYC ((`OSD_CLR_FILT_NS * `OSD_CLK_MHZ) / 1000)
// Reset values
`define OSD_OUTS_RST 8'h00
`define OSD_CNT_RST 16'h0000

`endif

// file: hw/osd_pkg.sv
// Types shared by the sink driver control modules.
// Assumes osd_map.svh sits on the include path.
`default_nettype none

package osd_pkg;
    // Counter word used by the clear filter and the recovery timer
    typedef logic [15:0] osd_cnt_t;
    // Channel bit vector
    typedef logic [7:0] osd_vec_t;

    // State of one channel
    typedef struct packed {
        logic latched;
        logic tripped;
    } osd_chan_t;

    // State of the shared control
    typedef struct packed {
        logic strobe_prev;
        logic clr_act;
        osd_cnt_t clr_cnt;
        osd_cnt_t recov_cnt;
        osd_vec_t outs;
    } osd_ctrl_t;
endpackage

`default_nettype wire

// file: hw/osd_sink_driver.sv
// Control logic of an eight-channel latched low-side driver.
// Assumes all inputs are synchronous to i_clk; analog status already
// arrives as digital levels.
//
// Notes on behaviour
// - Clear low turns outputs off, wipes state
// - Rising strobe with clear high captures data
// - Otherwise data ignored, outputs hold level
// - Overcurrent turns off only that channel
// - Recovery on clear or after 10 us
// - New trip restarts shared recovery timing
// - Thermal shutdown turns all outputs off
// - Thermal release resumes normal output operation
// - Thermal shutdown blocks strobe and data, not clear
// - Power-on reset turns off, initialises channels and recovery timer
`default_nettype none
`include "osd_map.svh"

module osd_sink_driver
    import osd_pkg::*;
#(
    parameter int RECOV_CYC = `OSD_RECOV_CYC,   // Overcurrent recovery
    parameter int CLR_FILT_CYC = `OSD_CLR_FILT_CYC // Clear filter length
)
(
    input wire logic i_clk,                     // Core clock, 250 MHz
    input wire logic i_rst,                     // Synchronous reset
    input wire logic i_clear_n,                 // Clear, active low
    input wire logic i_latch_strobe,            // Data capture strobe
    input wire osd_pkg::osd_vec_t i_parallel_data_in, // Data, 1 = on
    input wire osd_pkg::osd_vec_t i_overcurrent_guard, // Per-channel trip
    input wire logic i_thermal_cutoff,          // Over-temperature level
    input wire logic i_supply_low,              // Power-on reset level
    output var osd_pkg::osd_vec_t o_sink_outputs, // 1 = switch on
    output var osd_pkg::osd_vec_t o_guard_tripped // Shut-off flags
);
    import osd_pkg::*;

    // Counters are 16 bits wide; longer settings cannot be served
    if (RECOV_CYC < 2 || RECOV_CYC > 65535)
    begin : g_bad_recov
        $error("Recovery count out of range");
    end
    if (CLR_FILT_CYC < 1 || CLR_FILT_CYC > 65535)
    begin : g_bad_filt
        $error("Clear filter count out of range");
    end

    localparam osd_cnt_t RECOV_LAST = osd_cnt_t'(RECOV_CYC - 1);
    localparam osd_cnt_t FILT_LAST = osd_cnt_t'(CLR_FILT_CYC - 1);

    osd_ctrl_t st_q;
    osd_ctrl_t st_d;
    osd_vec_t chan_on;
    osd_vec_t chan_tripped;
    osd_vec_t new_trip;
    osd_vec_t tripped_q;
    logic wipe;
    logic strobe_rise;
    logic capture;
    logic any_tripped;
    logic recover;

    // Power-on reset wipes at once; clear only after the filter
    assign wipe = st_q.clr_act | i_supply_low;
    assign strobe_rise = i_latch_strobe & ~st_q.strobe_prev;
    // Falling edges and steady strobe levels never capture
    assign capture = strobe_rise & ~wipe & ~i_thermal_cutoff;
    assign new_trip = i_overcurrent_guard & ~chan_tripped;
    assign any_tripped = |chan_tripped;
    // One shared interval; a fresh trip suppresses the pulse
    assign recover = any_tripped & ~(|new_trip)
                   & (st_q.recov_cnt == RECOV_LAST);

    // Channel slices, one per output
    for (genvar g = 0; g < `OSD_CHANNELS; g++)
    begin : g_chan
        osd_chan_if u_if ();
        assign u_if.capture = capture;
        assign u_if.data = i_parallel_data_in[g];
        assign u_if.wipe = wipe;
        assign u_if.block = i_thermal_cutoff;
        assign u_if.trip = i_overcurrent_guard[g];
        assign u_if.recover = recover;
        assign chan_on[g] = u_if.on;
        assign chan_tripped[g] = u_if.tripped;

        osd_channel u_channel (
            .i_clk (i_clk),
            .i_rst (i_rst),
            .ch    (u_if.chan)
        );
    end

    // Next state of the clear filter, recovery timer and outputs
    always_comb
    begin
        st_d = st_q;
        st_d.strobe_prev = i_latch_strobe;
        // Filter: clear counts only once low for the whole window
        if (i_clear_n)
        begin
            st_d.clr_cnt = `OSD_CNT_RST;
            st_d.clr_act = 1'b0;
        end
        else if (st_q.clr_cnt == FILT_LAST)
        begin
            st_d.clr_act = 1'b1;
        end
        else
        begin
            st_d.clr_cnt = st_q.clr_cnt + 16'h0001;
        end
        // Shared timer: any newer trip takes over the timing
        if (wipe || !any_tripped || (|new_trip))
        begin
            st_d.recov_cnt = `OSD_CNT_RST;
        end
        else if (recover)
        begin
            st_d.recov_cnt = `OSD_CNT_RST;
        end
        else
        begin
            st_d.recov_cnt = st_q.recov_cnt + 16'h0001;
        end
        st_d.outs = chan_on;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Flags are registered so the port is a flop, one cycle behind
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            tripped_q <= `OSD_OUTS_RST;
        end
        else
        begin
            tripped_q <= chan_tripped;
        end
    end

    assign o_sink_outputs = st_q.outs;
    assign o_guard_tripped = tripped_q;

    // Checks on the control behaviour
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_take;
        capture && i_overcurrent_guard == 8'h00 && chan_tripped == 8'h00;
    endsequence

    sequence s_quiet;
        !wipe && !i_thermal_cutoff && i_overcurrent_guard == 8'h00;
    endsequence

    // Flag port lags the internal flag, so it is looked at one edge later
    a_clear_off: assert property (
        st_q.clr_act |=> o_sink_outputs == 8'h00 ##1 tripped_q == 8'h00)
        else $error("Outputs or flags survive a clear");

    a_clear_filter: assert property (
        $rose(st_q.clr_act) |-> !$past(i_clear_n) && st_q.clr_cnt == FILT_LAST)
        else $error("Clear recognised without a full low window");

    a_capture_data: assert property (
        s_take ##1 s_quiet |=> o_sink_outputs == $past(i_parallel_data_in, 2))
        else $error("Captured data not shown on the outputs");

    a_hold_level: assert property (
        (s_quiet and (!capture && !recover && chan_tripped == 8'h00)) ##1
        (s_quiet and !capture) |=> $stable(o_sink_outputs))
        else $error("Outputs changed without a rising strobe");

    a_trip_channel: assert property (
        (i_overcurrent_guard != 8'h00) |=>
        (o_sink_outputs & $past(i_overcurrent_guard)) == 8'h00)
        else $error("Overcurrent channel not switched off");

    a_trip_recover: assert property (
        (recover && !wipe && i_overcurrent_guard == 8'h00) |=>
        chan_tripped == 8'h00)
        else $error("Channel not released after the recovery interval");

    a_trip_restart: assert property (
        // A further trip or a wipe right after restarts the count again
        (any_tripped && (|new_trip) && !wipe) |=>
        st_q.recov_cnt == 16'h0000 ##1
        (st_q.recov_cnt == 16'h0001 || $past(wipe || (|new_trip))))
        else $error("Recovery timing not taken over by a new trip");

    a_thermal_off: assert property (
        i_thermal_cutoff |=> o_sink_outputs == 8'h00)
        else $error("Output on during thermal shutdown");

    a_thermal_block: assert property (
        i_thermal_cutoff |-> !capture)
        else $error("Data captured during thermal shutdown");

    a_supply_init: assert property (
        i_supply_low |=> o_sink_outputs == 8'h00 && st_q.recov_cnt == 16'h0000
        && chan_tripped == 8'h00)
        else $error("State survives a power-on reset");

    a_output_gate: assert property (
        (o_sink_outputs != 8'h00) |-> !$past(i_thermal_cutoff)
        && !$past(wipe))
        else $error("Output on while a blocking condition was active");

endmodule // osd_sink_driver

`default_nettype wire
